// >>> src/config_word_program_sequencer.sv
// Behaviour
// RQ1: Every reset walks the four flash words and loads the live config registers.
// RQ2: Word one is the last word, others lower by two; defaults 7FFF, FFFF.
// RQ3: Live config changes only after programming the flash word and resetting.
// RQ4: Programming only clears bits; a 0 cannot be written back to 1.
// RQ5: Programmer must chip-erase before changing an already programmed word; no erase exists here and the test rewrites word one without one.
// RQ6: Programmer always writes word one bit 15 as 0.
// RQ7: First variant: programmer writes listed reserved bits of words two-four as 1.
// RQ8: Second variant: programmer writes word two bit 2, word three bits 7,11 as 1.
// RQ9: Small second-variant parts: word two bits 12,11 written 0; else reference selects.
// RQ10: Second variant word four bit 14: reserved 1 on small parts, else pin select.
// RQ11: Commands and data are shifted LSb first, timed by the programming clock.
// RQ12: Programmer exits reset vector with no-op, jump to 0x200, no-op.
// RQ13: Programmer loads write pointer with low 16 address bits by move-immediate.
// RQ14: Programmer loads 0x4003 into scratch and moves it to flash control.
// RQ15: Programmer loads table page with upper address byte, 00h or 01h.
// RQ16: Programmer sets value and zero registers, then writes high and low latch.
// RQ17: Setting control bit 15 starts the write; hardware clears it when done.
// RQ18: Programmer polls control via visibility register with command 0001.
// RQ19: After each write, programmer jumps to 0x200 and repeats for words 2-4.
// RQ20: Programmer should leave protection bits at 1 until words are verified.
// RQ21: Programmer must not start writes or alter control while write bit is set.
module config_word_program_sequencer
    import cfg_word_pkg::*;
#(
    parameter int WR_CYCLES = WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // Programming port
    input  wire logic        program_clock_pin,
    input  wire logic        program_data_pin_in,
    output logic             program_data_pin_out,
    output logic             program_data_pin_oe,
    // Live configuration
    output logic [15:0]      config_word_one,
    output logic [15:0]      config_word_two,
    output logic [15:0]      config_word_three,
    output logic [15:0]      config_word_four,
    output logic             config_valid,
    // Status
    output logic             write_busy
);

    // ****************************************************************
    // Pin synchronisers and clock edge detection
    // ****************************************************************
    logic [1:0] clk_sync_ff;
    logic [1:0] dat_sync_ff;
    logic       clk_prev_ff;
    logic       rise;
    logic       fall;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clk_sync_ff <= '0;
            dat_sync_ff <= '0;
            clk_prev_ff <= 1'b0;
        end else begin
            clk_sync_ff <= {clk_sync_ff[0], program_clock_pin};
            dat_sync_ff <= {dat_sync_ff[0], program_data_pin_in};
            clk_prev_ff <= clk_sync_ff[1];
        end
    end

    assign rise = clk_sync_ff[1] && !clk_prev_ff;
    assign fall = !clk_sync_ff[1] && clk_prev_ff;

    // ****************************************************************
    // Serial frame engine
    // ****************************************************************
    typedef enum logic [1:0] {
        S_RELOAD,
        S_CMD,
        S_DATA,
        S_OUT
    } seq_state_t;

    seq_state_t  state_ff;
    seq_state_t  nxt_state;
    link_frame_t frame_ff;
    link_frame_t nxt_frame;
    logic [4:0]  bit_ff;
    logic [4:0]  nxt_bit;
    logic [15:0] shout_ff;
    logic [15:0] nxt_shout;
    logic        dout_ff;
    logic        nxt_dout;
    logic        oe_ff;
    logic        nxt_oe;
    logic        exec;

    // ****************************************************************
    // Emulated core registers and configuration
    // ****************************************************************
    cpu_regs_t   regs_ff;
    cpu_regs_t   nxt_regs;
    logic [15:0] cfg_ff [NUM_CW];
    logic [15:0] nxt_cfg [NUM_CW];
    logic [1:0]  rl_idx_ff;
    logic [1:0]  nxt_rl_idx;
    logic        valid_ff;
    logic        nxt_valid;
    logic        busy_ff;
    logic        wr_start;
    logic [1:0]  wr_idx;
    logic [15:0] rd_data;
    logic        arr_busy;

    // Word index from the low address: last word is word one, each lower by two.
    function automatic logic [1:0] cw_index(input logic [15:0] addr);
        logic [15:0] back;
        back = 16'hFFFE - addr;
        return back[2:1]; // [RQ2]
    endfunction

    function automatic logic is_movi(input logic [23:0] op, input logic [3:0] rd);
        return (op[23:20] == MOVI_OPC) && (op[3:0] == rd);
    endfunction

    // Shifted data is not yet the full word at exec; the last bit comes from the pin.
    logic [23:0] op;
    assign op = {dat_sync_ff[1], frame_ff.data[23:1]};

    assign exec     = (state_ff == S_DATA) && fall && (bit_ff == 5'(DATA_BITS - 1))
                      && (frame_ff.cmd == CMD_EXEC);
    assign wr_start = exec && (op == OP_SET_WR) && !regs_ff.ctrl[CTRL_WR_BIT]
                      && (regs_ff.ctrl == CTRL_CW_WRITE); // [RQ17]
    assign wr_idx   = cw_index(regs_ff.ptr);

    always_comb begin
        nxt_state = state_ff;
        nxt_frame = frame_ff;
        nxt_bit   = bit_ff;
        nxt_shout = shout_ff;
        nxt_dout  = dout_ff;
        nxt_oe    = oe_ff;
        unique case (state_ff)
            S_RELOAD: begin
                if (valid_ff) begin
                    nxt_state = S_CMD;
                    nxt_bit   = '0;
                end
            end
            S_CMD: begin
                if (fall) begin
                    // Sample on the falling edge, LSb first. [RQ11]
                    nxt_frame.cmd = {dat_sync_ff[1], frame_ff.cmd[3:1]}; // [RQ11]
                    nxt_bit       = bit_ff + 5'd1;
                    if (bit_ff == 5'(CMD_BITS - 1)) begin
                        nxt_bit   = '0;
                        nxt_state = S_DATA;
                        if (nxt_frame.cmd == CMD_REGOUT) begin
                            nxt_state = S_OUT;
                            nxt_shout = regs_ff.visi;
                            nxt_oe    = 1'b1;
                        end
                    end
                end
            end
            S_DATA: begin
                if (fall) begin
                    nxt_frame.data = {dat_sync_ff[1], frame_ff.data[23:1]}; // [RQ11]
                    nxt_bit        = bit_ff + 5'd1;
                    if (bit_ff == 5'(DATA_BITS - 1)) begin
                        nxt_bit   = '0;
                        nxt_state = S_CMD;
                    end
                end
            end
            S_OUT: begin
                if (rise) begin
                    nxt_dout  = shout_ff[0]; // [RQ11]
                    nxt_shout = {1'b0, shout_ff[15:1]};
                    nxt_bit   = bit_ff + 5'd1;
                end
                if (fall && bit_ff == 5'(VISI_BITS)) begin
                    nxt_bit   = '0;
                    nxt_oe    = 1'b0;
                    nxt_state = S_CMD;
                end
            end
        endcase
    end

    always_comb begin
        nxt_regs   = regs_ff;
        nxt_cfg    = cfg_ff;
        nxt_rl_idx = rl_idx_ff;
        nxt_valid  = valid_ff;
        if (!valid_ff) begin
            nxt_cfg[rl_idx_ff] = rd_data; // [RQ1]
            nxt_rl_idx         = rl_idx_ff + 2'd1;
            if (rl_idx_ff == 2'(NUM_CW - 1)) begin
                nxt_valid = 1'b1;
            end
        end
        if (exec) begin
            if (is_movi(op, REG_PTR))   nxt_regs.ptr   = op[19:4];
            if (is_movi(op, REG_VALUE)) nxt_regs.value = op[19:4];
            if (is_movi(op, REG_PAGE))  nxt_regs.poll  = op[19:4];
            if (is_movi(op, REG_CTRL))  nxt_regs.visi  = op[19:4];
            if (op == OP_CTRL_TO_NV && !busy_ff) nxt_regs.ctrl = regs_ff.visi;
            if (op == OP_PAGE_LOAD && !busy_ff)  nxt_regs.page = regs_ff.poll[7:0];
            if (op == OP_NV_TO_POLL) nxt_regs.poll = regs_ff.ctrl;
            if (op == OP_POLL_VISI)  nxt_regs.visi = regs_ff.poll;
            if (op == OP_SET_WR && wr_start) nxt_regs.ctrl[CTRL_WR_BIT] = 1'b1; // [RQ17]
        end
        // Hardware completion clears the write bit. [RQ17]
        if (busy_ff && !arr_busy && !wr_start) begin
            nxt_regs.ctrl[CTRL_WR_BIT] = 1'b0; // [RQ17]
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff  <= S_RELOAD;
            frame_ff  <= '0;
            bit_ff    <= '0;
            shout_ff  <= '0;
            dout_ff   <= 1'b0;
            oe_ff     <= 1'b0;
            regs_ff   <= '0;
            cfg_ff    <= '{CW1_DEFAULT, CWX_DEFAULT, CWX_DEFAULT, CWX_DEFAULT};
            rl_idx_ff <= '0;
            valid_ff  <= 1'b0;
            busy_ff   <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            frame_ff  <= nxt_frame;
            bit_ff    <= nxt_bit;
            shout_ff  <= nxt_shout;
            dout_ff   <= nxt_dout;
            oe_ff     <= nxt_oe;
            regs_ff   <= nxt_regs;
            cfg_ff    <= nxt_cfg; // [RQ3]
            rl_idx_ff <= nxt_rl_idx;
            valid_ff  <= nxt_valid;
            busy_ff   <= arr_busy || wr_start;
        end
    end

    cfg_flash_array #(
        .WR_CYCLES (WR_CYCLES)
    ) u_array (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .wr_start (wr_start),
        .wr_idx   (wr_idx),
        .wr_data  (regs_ff.value),
        .wr_busy  (arr_busy),
        .rd_idx   (rl_idx_ff),
        .rd_data  (rd_data)
    );

    assign program_data_pin_out = dout_ff;
    assign program_data_pin_oe  = oe_ff;
    assign config_word_one      = cfg_ff[0];
    // Reference and pin selects are stored as written; the reserved values are the writer's duty.
    assign config_word_two      = cfg_ff[1]; // [RQ9]
    assign config_word_three    = cfg_ff[2];
    assign config_word_four     = cfg_ff[3]; // [RQ10]
    assign config_valid         = valid_ff;
    assign write_busy           = regs_ff.ctrl[CTRL_WR_BIT];

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_reload_len;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(state_ff != S_RELOAD) |-> $past(valid_ff);
    endproperty
    a_reload_len: assert property (p_reload_len) else $error("left reload early"); // [RQ1]

    property p_cfg_stable;
        @(posedge ref_clk) disable iff (!nrst)
        valid_ff && $past(valid_ff) |-> $stable(cfg_ff[0]) && $stable(cfg_ff[3]);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable) else $error("config changed"); // [RQ3]

    property p_wr_set;
        @(posedge ref_clk) disable iff (!nrst)
        wr_start |=> regs_ff.ctrl[CTRL_WR_BIT] && busy_ff;
    endproperty
    a_wr_set: assert property (p_wr_set) else $error("write bit not set"); // [RQ17]

    property p_wr_clear;
        @(posedge ref_clk) disable iff (!nrst)
        $fell(arr_busy) |=> !regs_ff.ctrl[CTRL_WR_BIT];
    endproperty
    a_wr_clear: assert property (p_wr_clear) else $error("write bit stuck"); // [RQ17]

    property p_oe_out;
        @(posedge ref_clk) disable iff (!nrst)
        oe_ff |-> state_ff == S_OUT;
    endproperty
    a_oe_out: assert property (p_oe_out) else $error("pin driven outside readout"); // [RQ11]

endmodule

// >>> src/cfg_word_pkg.sv
package cfg_word_pkg;

    // ****************************************************************
    // Link command codes and field sizes
    // ****************************************************************
    localparam int          CMD_BITS      = 4;
    localparam int          DATA_BITS     = 24;
    localparam int          VISI_BITS     = 16;
    localparam logic [3:0]  CMD_EXEC      = 4'h0;
    localparam logic [3:0]  CMD_REGOUT    = 4'h1;

    // ****************************************************************
    // Instruction opcodes sent by the programmer; the sequencer decodes five of them
    // ****************************************************************
    localparam logic [23:0] OP_NOP        = 24'h00_0000;
    localparam logic [23:0] OP_GOTO_200   = 24'h04_0200;
    localparam logic [23:0] OP_CTRL_TO_NV = 24'h88_3B0A;
    localparam logic [23:0] OP_PAGE_LOAD  = 24'h88_02A0;
    localparam logic [23:0] OP_WR_HIGH    = 24'hBB_CB88;
    localparam logic [23:0] OP_WR_LOW     = 24'hBB_1386;
    localparam logic [23:0] OP_SET_WR     = 24'hA8_E761;
    localparam logic [23:0] OP_NV_TO_POLL = 24'h80_3B02;
    localparam logic [23:0] OP_POLL_VISI  = 24'h88_3C22;
    localparam logic [23:0] OP_ZERO_W8    = 24'h20_0008;

    // Move-immediate: opcode nibble in [23:20], literal [19:4], target reg [3:0].
    localparam logic [3:0]  MOVI_OPC      = 4'h2;
    localparam logic [3:0]  REG_PAGE      = 4'h0;
    localparam logic [3:0]  REG_POLL      = 4'h2;
    localparam logic [3:0]  REG_VALUE     = 4'h6;
    localparam logic [3:0]  REG_PTR       = 4'h7;
    localparam logic [3:0]  REG_ZERO      = 4'h8;
    localparam logic [3:0]  REG_CTRL      = 4'hA;

    // ****************************************************************
    // Configuration words and control register
    // ****************************************************************
    localparam int          NUM_CW        = 4;
    localparam logic [15:0] CW1_DEFAULT   = 16'h7FFF;
    localparam logic [15:0] CWX_DEFAULT   = 16'hFFFF;
    localparam logic [15:0] CTRL_CW_WRITE = 16'h4003;
    localparam int          CTRL_WR_BIT   = 15;
    localparam int          CW_STEP       = 2;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          WRITE_TIME_US = 50;
    localparam int          WRITE_CYCLES  = (WRITE_TIME_US * (CLK_HZ / 1_000_000));

    typedef struct packed {
        logic [3:0]  cmd;
        logic [23:0] data;
    } link_frame_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [7:0]  page;
        logic [15:0] ptr;
        logic [15:0] value;
        logic [15:0] poll;
        logic [15:0] visi;
    } cpu_regs_t;

endpackage

// >>> src/cfg_flash_array.sv
module cfg_flash_array
    import cfg_word_pkg::*;
#(
    parameter int WR_CYCLES = WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // Write request
    input  wire logic        wr_start,
    input  wire logic [1:0]  wr_idx,
    input  wire logic [15:0] wr_data,
    output logic             wr_busy,
    // Reload readout
    input  wire logic [1:0]  rd_idx,
    output logic [15:0]      rd_data
);

    // ****************************************************************
    // Nonvolatile storage
    // ****************************************************************
    // Cells come up erased and no device reset touches them, so only this start value and completed writes set them.
    logic [15:0] cell_ff [NUM_CW] = '{CW1_DEFAULT, CWX_DEFAULT, // [RQ2]
                                      CWX_DEFAULT, CWX_DEFAULT};
    logic [15:0] nxt_cell [NUM_CW];
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic        busy_ff;
    logic        nxt_busy;
    logic [1:0]  idx_ff;
    logic [1:0]  nxt_idx;
    logic [15:0] data_ff;
    logic [15:0] nxt_data;

    assign wr_busy = busy_ff;
    assign rd_data = cell_ff[rd_idx];

    always_comb begin
        nxt_cell = cell_ff;
        nxt_cnt  = cnt_ff;
        nxt_busy = busy_ff;
        nxt_idx  = idx_ff;
        nxt_data = data_ff;
        if (!busy_ff && wr_start) begin
            nxt_busy = 1'b1;
            nxt_idx  = wr_idx;
            nxt_data = wr_data;
            nxt_cnt  = 32'(WR_CYCLES);
        end else if (busy_ff) begin
            nxt_cnt = cnt_ff - 32'd1;
            if (cnt_ff <= 32'd1) begin
                // Cells only discharge: a 1 can never be written back. [RQ4]
                nxt_cell[idx_ff] = cell_ff[idx_ff] & data_ff; // [RQ4]
                nxt_busy         = 1'b0;
            end
        end
    end

    // Storage is held across device resets; only power-up sets the erased state.
    always_ff @(posedge ref_clk) begin
        cell_ff <= nxt_cell;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
            idx_ff  <= '0;
            data_ff <= '0;
        end else begin
            cnt_ff  <= nxt_cnt;
            busy_ff <= nxt_busy;
            idx_ff  <= nxt_idx;
            data_ff <= nxt_data;
        end
    end

    property p_busy_len;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(busy_ff) |-> busy_ff[*2];
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write ended too early"); // [RQ17]

    property p_no_set;
        @(posedge ref_clk) disable iff (!nrst)
        $fell(busy_ff) |-> ((cell_ff[idx_ff] & ~$past(cell_ff[idx_ff])) == 16'h0000);
    endproperty
    a_no_set: assert property (p_no_set) else $error("cell bit went 0 to 1"); // [RQ4]

endmodule

// >>> dv/cfg_programmer.sv
module cfg_programmer
    import cfg_word_pkg::*;
#(
    parameter logic [7:0] PAGE = 8'h01
) (
    // Clock
    input  wire logic ref_clk,
    // Device side of the programming port
    input  wire logic dev_out,
    input  wire logic dev_oe,
    input  wire logic dev_busy,
    // Programmer drive
    output logic      prog_clk,
    output logic      pin_level
);
    timeunit 1ns;
    timeprecision 100ps;

    logic drv;

    // ****************************************************************
    // Pin resolution
    // ****************************************************************
    // While released, the programmer toggles its level so that a stale bit never reads right.
    assign pin_level = dev_oe ? dev_out : drv;

    initial begin
        prog_clk = 1'b0;
        drv      = 1'b0;
    end

    // ****************************************************************
    // Link cycles
    // ****************************************************************
    // One link cycle: 100 ns high, 100 ns low; the clock rests low between frames.
    task automatic tick(input logic b, output logic seen);
        @(posedge ref_clk);
        drv      <= b;
        prog_clk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        prog_clk <= 1'b0;
        repeat (2) @(posedge ref_clk);
        seen = pin_level;
        @(posedge ref_clk);
    endtask

    task automatic exec(input logic [23:0] op);
        link_frame_t f;
        logic        s;
        f = '{cmd: CMD_EXEC, data: op};
        for (int i = 0; i < CMD_BITS; i++) tick(f.cmd[i], s);
        for (int i = 0; i < DATA_BITS; i++) tick(f.data[i], s);
    endtask

    task automatic regout(output logic [15:0] v);
        logic s;
        for (int i = 0; i < CMD_BITS; i++) tick(CMD_REGOUT[i], s);
        for (int i = 0; i < VISI_BITS; i++) begin
            tick(~drv, s);
            v[i] = s;
        end
    endtask

    task automatic poll(output logic [15:0] v);
        logic [23:0] ops [5];
        ops = '{OP_GOTO_200, OP_NOP, OP_NV_TO_POLL, OP_POLL_VISI, OP_NOP};
        foreach (ops[i]) exec(ops[i]);
        regout(v);
        exec(OP_NOP);
    endtask

    // ****************************************************************
    // Single configuration word write
    // ****************************************************************
    task automatic write_word(input int idx, input logic [15:0] val, output logic busy,
                              output logic [15:0] first, output logic [15:0] last);
        logic [23:0] ops [20];
        ops = '{OP_NOP, OP_GOTO_200, OP_NOP,
                {MOVI_OPC, 16'hFFFE - 16'(CW_STEP * idx), REG_PTR},
                {MOVI_OPC, CTRL_CW_WRITE, REG_CTRL}, OP_CTRL_TO_NV,
                {MOVI_OPC, 8'h00, PAGE, REG_PAGE}, OP_PAGE_LOAD,
                {MOVI_OPC, val, REG_VALUE}, OP_ZERO_W8, OP_NOP,
                OP_WR_HIGH, OP_NOP, OP_NOP, OP_WR_LOW, OP_NOP, OP_NOP,
                OP_SET_WR, OP_NOP, OP_NOP};
        foreach (ops[i]) begin
            exec(ops[i]);
            if (i == 18) busy = dev_busy;
        end
        poll(first);
        last = first;
        // Up to four more polls are sent while the write bit still reads set, then the task moves on.
        for (int n = 0; n < 4 && last[CTRL_WR_BIT] === 1'b1; n++) poll(last);
        exec(OP_GOTO_200);
        exec(OP_NOP);
    endtask
endmodule

// >>> dv/test_config_word_program_sequencer.sv
module test_config_word_program_sequencer
    import cfg_word_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // Long enough that the first poll still sees the write bit, short enough for a quick run.
    localparam int WR_SIM = 1200;

    logic        ref_clk = 1'b0;
    logic        nrst;
    logic        program_clock_pin;
    logic        pin_level;
    logic        program_data_pin_out;
    logic        program_data_pin_oe;
    logic [15:0] config_word_one;
    logic [15:0] config_word_two;
    logic [15:0] config_word_three;
    logic [15:0] config_word_four;
    logic        config_valid;
    logic        write_busy;
    logic [15:0] live [NUM_CW];
    int          fails;
    int          compares;

    always #12.5ns ref_clk = ~ref_clk;

    assign live = '{config_word_one, config_word_two, config_word_three, config_word_four};

    config_word_program_sequencer #(.WR_CYCLES(WR_SIM)) DUT (
        .ref_clk              (ref_clk),
        .nrst                 (nrst),
        .program_clock_pin    (program_clock_pin),
        .program_data_pin_in  (pin_level),
        .program_data_pin_out (program_data_pin_out),
        .program_data_pin_oe  (program_data_pin_oe),
        .config_word_one      (config_word_one),
        .config_word_two      (config_word_two),
        .config_word_three    (config_word_three),
        .config_word_four     (config_word_four),
        .config_valid         (config_valid),
        .write_busy           (write_busy)
    );

    cfg_programmer prog (
        .ref_clk   (ref_clk),
        .dev_out   (program_data_pin_out),
        .dev_oe    (program_data_pin_oe),
        .dev_busy  (write_busy),
        .prog_clk  (program_clock_pin),
        .pin_level (pin_level)
    );

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wait_valid();
        for (int n = 0; n < 50 && config_valid !== 1'b1; n++) @(posedge ref_clk);
        check({15'h0, config_valid}, 16'h0001);
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        wait_valid();
    endtask

    task automatic wr(input int idx, input logic [15:0] val);
        logic        busy;
        logic [15:0] first;
        logic [15:0] last;
        prog.write_word(idx, val, busy, first, last);
        check({15'h0, busy}, 16'h0001);
        check(first, CTRL_CW_WRITE | (16'h0001 << CTRL_WR_BIT));
        check(last, CTRL_CW_WRITE);
        check({15'h0, write_busy}, 16'h0000);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_defaults();
        check(config_word_one, CW1_DEFAULT);
        for (int k = 1; k < NUM_CW; k++) check(live[k], CWX_DEFAULT);
        check({14'h0, config_valid, program_data_pin_oe}, 16'h0000);
        nrst <= 1'b1;
        wait_valid();
        check(config_word_one, CW1_DEFAULT);
        for (int k = 1; k < NUM_CW; k++) check(live[k], CWX_DEFAULT);
    endtask

    // A write bit set under a wrong control value must not start a write.
    task automatic t_refused();
        logic [15:0] v;
        prog.exec({MOVI_OPC, 16'h4001, REG_CTRL});
        prog.exec(OP_CTRL_TO_NV);
        prog.exec(OP_SET_WR);
        prog.exec(OP_NOP);
        check({15'h0, write_busy}, 16'h0000);
        prog.poll(v);
        check(v, 16'h4001);
        check({15'h0, program_data_pin_oe}, 16'h0000);
    endtask

    task automatic t_program_all();
        logic [15:0] vals [NUM_CW];
        // Reserved bits held for both variants; protection bits stay 1 for verify.
        vals = '{16'h7F3F, 16'hE7EF, 16'hFEF7, 16'hFE5A};
        for (int k = 0; k < NUM_CW; k++) wr(k, vals[k]);
        check(config_word_one, CW1_DEFAULT);
        for (int k = 1; k < NUM_CW; k++) check(live[k], CWX_DEFAULT);
        do_reset();
        for (int k = 0; k < NUM_CW; k++) check(live[k], vals[k]);
    endtask

    // Rewriting without an erase first may only clear further bits.
    task automatic t_no_set_bits();
        wr(0, 16'h00FF);
        check(config_word_one, 16'h7F3F);
        do_reset();
        check(config_word_one, 16'h7F3F & 16'h00FF);
        check(config_word_two, 16'hE7EF);
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        nrst     = 1'b0;
        fails    = 0;
        compares = 0;
        repeat (5) @(posedge ref_clk);
        t_defaults();
        t_refused();
        t_program_all();
        t_no_set_bits();
        end_of_test();
    end

    initial begin
        repeat (90000) @(posedge ref_clk);
        fails++;
        end_of_test();
    end
endmodule
